/* hdl/dsa_seq.sv */
// Dual-slope converter sequencer with digit scan and APB register access
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "dsa_defines.svh"
// Summary of operation
// - Each cycle runs system zero, input integrate, reference integrate, zero.
// - Switch sets per phase; reference switch follows the captured sign.
// - Integrate input fixed counts, then reference until zero, counting.
// - Input sign is taken at end of input integration.
// - Integrator zero lasts 200 clocks, or 6200 after an overrange.
// - With run/hold high, a new cycle starts every 40,002 clocks.
// - Run/hold low finishes the current cycle, then holds the result.
// - In hold, a run/hold pulse over 300 ns starts one cycle.
// - A single-shot cycle opens with 10,001 counts of auto zero.
// - Five active-low strobes per result, centred in digit selects.
// - Msd select high 201 counts; first strobe 101 clocks after its rise.
// - Later digit selects high 200 clocks; strobe 100 clocks after rise.
// - Scan repeats for refresh; strobes only once per new result.
// - After an overrange, scanning stops until the next reference phase.
// - Busy high from input integration until just after zero crossing.
// - Overrange beyond 20,000 counts, set as busy falls, cleared later.
// - Polarity output high means a positive input.
// - BCD bits positive-true, timed with selects, zero in overrange.
module dsa_seq #(
    parameter int INT_CYC   = `DSA_INT_CYC,
    parameter int DEINT_MAX = `DSA_DEINT_MAX,
    parameter int FRAME_CYC = `DSA_FRAME_CYC,
    parameter int AZ_CYC    = `DSA_AZ_SINGLE,
    parameter int IZ_OVR    = `DSA_IZ_OVR
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              run_hold,
    input  wire logic              comp_positive,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output dsa_pkg::dsa_phase_type phase,
    output logic                   input_connect_switch,
    output logic                   ref_positive_switch,
    output logic                   ref_negative_switch,
    output logic                   zeroing_switch,
    output logic                   ref_charge_switch,
    output logic                   feedback_loop_switch,
    output logic                   integrator_clear_switch,
    output logic                   busy,
    output logic                   polarity,
    output logic                   overrange,
    output logic                   underrange,
    output wire logic              digit_select_msd,
    output wire logic              digit_select_fourth,
    output wire logic              digit_select_third,
    output wire logic              digit_select_second,
    output wire logic              digit_select_lsd,
    output wire logic              bcd_bit_msb,
    output wire logic              bcd_bit_weight_four,
    output wire logic              bcd_bit_weight_two,
    output wire logic              bcd_bit_lsb,
    output wire logic              strobe_n
);
    import dsa_pkg::*;

    localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYC - 1);
    localparam logic [15:0] AZ_START   = 16'(FRAME_CYC - AZ_CYC);
    localparam logic [15:0] INT_LAST   = 16'(INT_CYC - 1);
    localparam logic [15:0] DEINT_LAST = 16'(INT_CYC + DEINT_MAX);
    localparam logic [15:0] IZ_NORM_C  = 16'(`DSA_IZ_NORM);
    localparam logic [15:0] IZ_OVR_C   = 16'(IZ_OVR);
    localparam logic [7:0]  RUN_CYC    = 8'(`DSA_RUN_PULSE_CYC);

    // The frame must hold the longest overrange conversion plus two clocks
    if (FRAME_CYC > 65535 || AZ_CYC < 1 || AZ_CYC >= FRAME_CYC
        || INT_CYC + DEINT_MAX + IZ_OVR + 2 > FRAME_CYC
        || `DSA_RUN_PULSE_CYC > 254)
    begin : g_bad_param
        $error("dsa_seq: timing parameters out of range");
    end

    dsa_phase_type state_r;
    dsa_phase_type state_nxt;
    logic [15:0]   cnt_r;
    logic [15:0]   cnt_nxt;
    logic [15:0]   iz_end_r;
    logic [15:0]   iz_end_nxt;
    logic [19:0]   count_r;
    logic [19:0]   count_nxt;
    logic [19:0]   result_r;
    logic [19:0]   result_nxt;
    logic [19:0]   count_inc;
    logic [7:0]    run_cnt_r;
    logic [7:0]    run_cnt_nxt;
    logic [6:0]    sw_nxt;
    logic          busy_nxt;
    logic          pol_nxt;
    logic          ovr_nxt;
    logic          under_nxt;
    logic          load_r;
    logic          load_nxt;
    logic          resume_r;
    logic          resume_nxt;
    logic          ctrl_en_r;
    logic          ctrl_en_nxt;
    logic          run_ok;
    logic          crossed;
    logic [31:0]   prdata_nxt;
    logic          pready_nxt;
    logic          pslverr_nxt;

    // BCD increment of the de-integration count, one carry stage per digit
    for (genvar d = 0; d < 5; d++)
    begin : g_bcd
        logic carry_in;
        if (d == 0)
        begin : g_lsd
            assign carry_in = 1'b1;
        end
        else
        begin : g_up
            assign carry_in = g_bcd[d-1].carry_in
                && count_r[4*(d-1) +: 4] == 4'h9;
        end
        assign count_inc[4*d +: 4] = !carry_in ? count_r[4*d +: 4]
            : (count_r[4*d +: 4] == 4'h9) ? 4'h0 : count_r[4*d +: 4] + 4'h1;
    end

    assign run_ok  = run_hold && ctrl_en_r;
    assign crossed = comp_positive != polarity;

    always_comb
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r + 16'h0001;
        iz_end_nxt  = iz_end_r;
        count_nxt   = count_r;
        result_nxt  = result_r;
        run_cnt_nxt = 8'h00;
        busy_nxt    = busy;
        pol_nxt     = polarity;
        ovr_nxt     = overrange;
        under_nxt   = underrange;
        load_nxt    = 1'b0;
        resume_nxt  = 1'b0;
        case (state_r)
            DSA_ZERO:
            begin
                if (cnt_r == FRAME_LAST)
                begin
                    state_nxt = DSA_INTEG;
                    cnt_nxt   = 16'h0000;
                    busy_nxt  = 1'b1;
                    under_nxt = 1'b0;
                end
            end
            DSA_INTEG:
            begin
                if (cnt_r == INT_LAST)
                begin
                    state_nxt  = DSA_DEINT;
                    pol_nxt    = comp_positive;
                    ovr_nxt    = 1'b0;
                    count_nxt  = 20'h00000;
                    resume_nxt = 1'b1;
                end
            end
            DSA_DEINT:
            begin
                count_nxt = count_inc;
                if (crossed || cnt_r == DEINT_LAST)
                begin
                    state_nxt  = DSA_IZERO;
                    count_nxt  = count_r;
                    result_nxt = count_r;
                    busy_nxt   = 1'b0;
                    ovr_nxt    = !crossed;
                    under_nxt  = count_r <= `DSA_UNDER_BCD;
                    load_nxt   = 1'b1;
                    iz_end_nxt = cnt_r + (crossed ? IZ_NORM_C : IZ_OVR_C);
                end
            end
            DSA_IZERO:
            begin
                if (cnt_r == iz_end_r)
                begin
                    state_nxt = run_ok ? DSA_ZERO : DSA_HOLD;
                end
            end
            default:
            begin
                cnt_nxt = cnt_r;
                // Hold ends only on a qualified high level, never a glitch
                if (run_ok)
                begin
                    run_cnt_nxt = run_cnt_r + 8'h01;
                    if (run_cnt_r == RUN_CYC)
                    begin
                        state_nxt   = DSA_ZERO;
                        cnt_nxt     = AZ_START;
                        run_cnt_nxt = 8'h00;
                    end
                end
            end
        endcase
        // Idle hold keeps the auto-zero loop closed
        case (state_nxt)
            DSA_INTEG: sw_nxt = 7'h40;
            DSA_DEINT: sw_nxt = pol_nxt ? 7'h22 : 7'h12;
            DSA_IZERO: sw_nxt = 7'h03;
            default:   sw_nxt = 7'h0E;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_r   <= DSA_ZERO;
            cnt_r     <= AZ_START;
            iz_end_r  <= 16'h0000;
            count_r   <= 20'h00000;
            result_r  <= 20'h00000;
            run_cnt_r <= 8'h00;
            load_r    <= 1'b0;
            resume_r  <= 1'b0;
            phase     <= DSA_ZERO;
            busy      <= 1'b0;
            polarity  <= 1'b0;
            overrange <= 1'b0;
            underrange <= 1'b0;
            {input_connect_switch, ref_positive_switch, ref_negative_switch,
             zeroing_switch, ref_charge_switch, feedback_loop_switch,
             integrator_clear_switch} <= 7'h0E;
        end
        else
        begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            iz_end_r  <= iz_end_nxt;
            count_r   <= count_nxt;
            result_r  <= result_nxt;
            run_cnt_r <= run_cnt_nxt;
            load_r    <= load_nxt;
            resume_r  <= resume_nxt;
            phase     <= state_nxt;
            busy      <= busy_nxt;
            polarity  <= pol_nxt;
            overrange <= ovr_nxt;
            underrange <= under_nxt;
            {input_connect_switch, ref_positive_switch, ref_negative_switch,
             zeroing_switch, ref_charge_switch, feedback_loop_switch,
             integrator_clear_switch} <= sw_nxt;
        end
    end

    // APB slave: one wait state so that read data leaves a flip-flop
    always_comb
    begin
        pready_nxt  = psel && penable && !pready;
        pslverr_nxt = 1'b0;
        prdata_nxt  = prdata;
        ctrl_en_nxt = ctrl_en_r;
        if (psel && penable && !pready)
        begin
            prdata_nxt = 32'h00000000;
            if (paddr == `DSA_CTRL_OFS)
                prdata_nxt = {31'h00000000, ctrl_en_r};
            else if (paddr == `DSA_STATUS_OFS)
                prdata_nxt = {23'h000000, state_r, underrange, overrange,
                              polarity, busy};
            else if (paddr == `DSA_RESULT_OFS)
                prdata_nxt = {12'h000, result_r};
            else
                pslverr_nxt = 1'b1;
        end
        if (psel && penable && pready && pwrite && paddr == `DSA_CTRL_OFS)
            ctrl_en_nxt = pwdata[0];
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            prdata    <= 32'h00000000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            ctrl_en_r <= `DSA_CTRL_RST;
        end
        else
        begin
            prdata    <= prdata_nxt;
            pready    <= pready_nxt;
            pslverr   <= pslverr_nxt;
            ctrl_en_r <= ctrl_en_nxt;
        end
    end

    dsa_scan u_scan (
        .clock     (clock),
        .rst       (rst),
        .load      (load_r),
        .resume    (resume_r),
        .ovr       (overrange),
        .value     (result_r),
        .digit_sel ({digit_select_msd, digit_select_fourth,
                     digit_select_third, digit_select_second,
                     digit_select_lsd}),
        .bcd       ({bcd_bit_msb, bcd_bit_weight_four,
                     bcd_bit_weight_two, bcd_bit_lsb}),
        .strobe_n  (strobe_n)
    );

    // Helpers read only by the assertions
    logic [15:0] gap_r;
    logic [15:0] iz_cnt_r;
    logic        held_r;
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            gap_r    <= 16'h0000;
            iz_cnt_r <= 16'h0000;
            held_r   <= 1'b1;
        end
        else
        begin
            // Restart on entry to integration so the gap spans a whole frame
            gap_r    <= (state_nxt == DSA_INTEG && state_r != DSA_INTEG)
                      ? 16'h0000 : gap_r + 16'h0001;
            iz_cnt_r <= (state_r == DSA_IZERO) ? iz_cnt_r + 16'h0001 : 16'h0000;
            held_r   <= (state_r == DSA_INTEG) ? 1'b0
                      : (state_r == DSA_HOLD) ? 1'b1 : held_r;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    phase_order_a : assert property (
        $changed(state_r) |-> $past(state_r) == DSA_HOLD
        || state_r == dsa_phase_type'({$past(state_r[3:0]), 1'b0})
        || (state_r == DSA_ZERO && $past(state_r) == DSA_IZERO))
        else $error("phase order broken");
    switch_set_a : assert property (
        state_r == DSA_DEINT |-> feedback_loop_switch
        && ref_positive_switch == polarity && ref_negative_switch != polarity
        && !input_connect_switch)
        else $error("wrong switches in reference phase");
    int_length_a : assert property (
        $rose(state_r == DSA_DEINT) |-> $past(state_r == DSA_INTEG,
        INT_CYC > 300 ? 300 : INT_CYC) && cnt_r == INT_LAST + 16'h0001)
        else $error("input integration length wrong");
    sign_capture_a : assert property (
        $rose(state_r == DSA_DEINT) |-> polarity == $past(comp_positive))
        else $error("sign not taken at end of integration");
    iz_length_a : assert property (
        $fell(state_r == DSA_IZERO) |-> $past(iz_cnt_r) + 16'h0001
        == (overrange ? IZ_OVR_C : IZ_NORM_C))
        else $error("integrator zero length wrong");
    frame_period_a : assert property (
        $rose(state_r == DSA_INTEG) && !$past(held_r)
        |-> $past(gap_r) == FRAME_LAST)
        else $error("continuous frame period wrong");
    hold_stays_a : assert property (
        state_r == DSA_HOLD && !run_hold |=> state_r == DSA_HOLD)
        else $error("hold left without a run pulse");
    single_shot_a : assert property (
        state_r == DSA_HOLD ##1 state_r == DSA_ZERO
        |-> $past(run_hold, 2) && cnt_r == AZ_START)
        else $error("single shot started wrongly");
    busy_window_a : assert property (
        busy == (state_r == DSA_DEINT || state_r == DSA_INTEG))
        else $error("busy outside integration phases");
    ovr_clear_a : assert property (
        $fell(overrange) |-> $rose(state_r == DSA_DEINT))
        else $error("overrange cleared at wrong time");

    cover property ($rose(overrange));
    cover property ($rose(state_r == DSA_HOLD));
    cover property (state_r == DSA_HOLD ##1 state_r == DSA_ZERO);
    cover property ($fell(busy) && !overrange);
endmodule : dsa_seq

/* hdl/dsa_defines.svh */
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef DSA_DEFINES_SVH
`define DSA_DEFINES_SVH
`define DSA_CLK_PERIOD_NS  4
`define DSA_RUN_PULSE_NS   300
`define DSA_RUN_PULSE_CYC  ((`DSA_RUN_PULSE_NS + `DSA_CLK_PERIOD_NS - 1) / `DSA_CLK_PERIOD_NS)
`define DSA_INT_CYC        10000
`define DSA_DEINT_MAX      20000
`define DSA_FRAME_CYC      40002
`define DSA_AZ_SINGLE      10001
`define DSA_IZ_NORM        200
`define DSA_IZ_OVR         6200
`define DSA_UNDER_BCD      20'h01800
`define DSA_MSD_LEN        201
`define DSA_DIG_LEN        200
`define DSA_MSD_STB        101
`define DSA_DIG_STB        100
`define DSA_CTRL_OFS       8'h00
`define DSA_STATUS_OFS     8'h04
`define DSA_RESULT_OFS     8'h08
`define DSA_CTRL_RST       1'b1
`define DSA_ST_BUSY        0
`define DSA_ST_POL         1
`define DSA_ST_OVR         2
`define DSA_ST_UNDER       3
`define DSA_ST_PHASE       4
`endif

/* hdl/dsa_pkg.sv */
// Types shared by the sequencer and the digit scanner
package dsa_pkg;
    typedef enum logic [4:0] {
        DSA_ZERO  = 5'h01,
        DSA_INTEG = 5'h02,
        DSA_DEINT = 5'h04,
        DSA_IZERO = 5'h08,
        DSA_HOLD  = 5'h10
    } dsa_phase_type;
endpackage : dsa_pkg

/* hdl/dsa_scan.sv */
// Multiplexed digit scan with one strobe burst per new result
`timescale 1ns/10ps
`include "dsa_defines.svh"
module dsa_scan #(
    parameter int MSD_LEN = `DSA_MSD_LEN,
    parameter int DIG_LEN = `DSA_DIG_LEN,
    parameter int MSD_STB = `DSA_MSD_STB,
    parameter int DIG_STB = `DSA_DIG_STB
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic        resume,
    input  wire logic        ovr,
    input  wire logic [19:0] value,
    output logic      [4:0]  digit_sel,
    output logic      [3:0]  bcd,
    output logic             strobe_n
);
    import dsa_pkg::*;

    localparam logic [7:0] MSD_LAST = 8'(MSD_LEN - 1);
    localparam logic [7:0] DIG_LAST = 8'(DIG_LEN - 1);
    localparam logic [7:0] MSD_AT   = 8'(MSD_STB);
    localparam logic [7:0] DIG_AT   = 8'(DIG_STB);

    if (MSD_LEN > 256 || DIG_LEN > 256 || MSD_STB >= MSD_LEN
        || DIG_STB >= DIG_LEN)
    begin : g_bad_param
        $error("dsa_scan: scan timing out of range");
    end

    logic [2:0]  dig_r;
    logic [2:0]  dig_nxt;
    logic [7:0]  pos_r;
    logic [7:0]  pos_nxt;
    logic        armed_r;
    logic        armed_nxt;
    logic        blank_r;
    logic        blank_nxt;
    logic        ovr_r;
    logic        ovr_nxt;
    logic [19:0] val_r;
    logic [19:0] val_nxt;
    logic [4:0]  sel_nxt;
    logic [3:0]  bcd_nxt;
    logic        stb_nxt;
    logic [7:0]  stb_at;

    always_comb
    begin
        dig_nxt   = dig_r;
        pos_nxt   = pos_r + 8'h01;
        armed_nxt = armed_r;
        blank_nxt = blank_r;
        ovr_nxt   = ovr_r;
        val_nxt   = val_r;
        if (load)
        begin
            dig_nxt   = 3'h4;
            pos_nxt   = 8'h00;
            armed_nxt = 1'b1;
            blank_nxt = 1'b0;
            ovr_nxt   = ovr;
            val_nxt   = value;
        end
        else if (resume && blank_r)
        begin
            dig_nxt   = 3'h4;
            pos_nxt   = 8'h00;
            blank_nxt = 1'b0;
        end
        else if (pos_r == ((dig_r == 3'h4) ? MSD_LAST : DIG_LAST))
        begin
            pos_nxt = 8'h00;
            dig_nxt = (dig_r == 3'h0) ? 3'h4 : dig_r - 3'h1;
            if (dig_r == 3'h0)
            begin
                armed_nxt = 1'b0;
            end
        end
        // Blank right after the last strobe of an overrange result
        if (!load && ovr_r && armed_r && dig_r == 3'h0 && pos_r == DIG_AT)
        begin
            blank_nxt = 1'b1;
            armed_nxt = 1'b0;
        end
        stb_at  = (dig_nxt == 3'h4) ? MSD_AT : DIG_AT;
        sel_nxt = blank_nxt ? 5'h00 : 5'(5'h01 << dig_nxt);
        bcd_nxt = (blank_nxt || ovr_nxt) ? 4'h0
                : val_nxt[{dig_nxt, 2'b00} +: 4];
        stb_nxt = !(armed_nxt && pos_nxt == stb_at);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            dig_r     <= 3'h4;
            pos_r     <= 8'h00;
            armed_r   <= 1'b0;
            blank_r   <= 1'b0;
            ovr_r     <= 1'b0;
            val_r     <= 20'h00000;
            digit_sel <= 5'h10;
            bcd       <= 4'h0;
            strobe_n  <= 1'b1;
        end
        else
        begin
            dig_r     <= dig_nxt;
            pos_r     <= pos_nxt;
            armed_r   <= armed_nxt;
            blank_r   <= blank_nxt;
            ovr_r     <= ovr_nxt;
            val_r     <= val_nxt;
            digit_sel <= sel_nxt;
            bcd       <= bcd_nxt;
            strobe_n  <= stb_nxt;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    strobe_in_digit_a : assert property (
        !strobe_n |-> $onehot(digit_sel) && pos_r == stb_at)
        else $error("strobe low outside the centre of a digit");
    strobe_one_cycle_a : assert property (
        $fell(strobe_n) |=> strobe_n)
        else $error("strobe low for more than one cycle");
    msd_strobe_at_a : assert property (
        $rose(digit_sel[4]) && load == 1'b0 && $past(load)
        |-> ##100 strobe_n ##1 !strobe_n)
        else $error("first strobe not 101 clocks into the msd slot");
    cover property ($fell(strobe_n) && digit_sel[0]);
endmodule : dsa_scan

/* verif/dsa_latch.sv */
// Far-end latch that grabs the selected BCD digit on each strobe
`timescale 1ns/10ps
module dsa_latch (
    input  wire logic        clock,
    input  wire logic [4:0]  sel,
    input  wire logic [3:0]  bcd,
    input  wire logic        strobe_n,
    output logic      [19:0] word
);
    // A strobe outside exactly one digit slot poisons the word
    always @(posedge clock)
    begin
        if (strobe_n === 1'b0)
        begin
            case (sel)
                5'h10:   word[19:16] <= bcd;
                5'h08:   word[15:12] <= bcd;
                5'h04:   word[11:8]  <= bcd;
                5'h02:   word[7:4]   <= bcd;
                5'h01:   word[3:0]   <= bcd;
                default: word        <= 20'hEEEEE;
            endcase
        end
    end
endmodule : dsa_latch

/* verif/testbench.sv */
// Self-checking bench: conversions, hold, digit scan and APB access
`timescale 1ns/10ps
module testbench;
    import dsa_pkg::*;
    localparam int INT = 20;
    localparam int DMAX = 40;
    localparam int FRAME = 1200;
    localparam int AZ = 21;
    localparam int IZO = 30;
    logic clock = 1'b0, rst = 1'b1, run_hold = 1'b1, comp_positive = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, in_pos = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, s_in, s_rp, s_rn, s_z, s_rc, s_lp, s_cl;
    logic busy, polarity, overrange, underrange, strobe_n;
    wire [4:0]   sel;
    wire [3:0]   bcd;
    logic [19:0] word;
    dsa_phase_type phase;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, dcnt = 0, dlen = 0;
    int n, t0, t_az, t_int = 0, lsd_hi = 0;
    int stb_t[$];

    always #2 clock = ~clock;

    dsa_seq #(.INT_CYC(INT), .DEINT_MAX(DMAX), .FRAME_CYC(FRAME),
        .AZ_CYC(AZ), .IZ_OVR(IZO)) dut_u (
        .clock(clock), .rst(rst), .run_hold(run_hold),
        .comp_positive(comp_positive), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phase(phase),
        .input_connect_switch(s_in), .ref_positive_switch(s_rp),
        .ref_negative_switch(s_rn), .zeroing_switch(s_z),
        .ref_charge_switch(s_rc), .feedback_loop_switch(s_lp),
        .integrator_clear_switch(s_cl), .busy(busy), .polarity(polarity),
        .overrange(overrange), .underrange(underrange),
        .digit_select_msd(sel[4]), .digit_select_fourth(sel[3]),
        .digit_select_third(sel[2]), .digit_select_second(sel[1]),
        .digit_select_lsd(sel[0]), .bcd_bit_msb(bcd[3]),
        .bcd_bit_weight_four(bcd[2]), .bcd_bit_weight_two(bcd[1]),
        .bcd_bit_lsb(bcd[0]), .strobe_n(strobe_n));
    dsa_latch far_u (.clock(clock), .sel(sel), .bcd(bcd),
        .strobe_n(strobe_n), .word(word));

    // Integrator stand-in: comparator flips after dlen reference cycles
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        dcnt <= (phase === DSA_DEINT) ? dcnt + 1 : 0;
        comp_positive <= (phase === DSA_DEINT && dcnt + 1 >= dlen)
            ? !in_pos : in_pos;
        if (strobe_n === 1'b0)
            stb_t.push_back(cyc);
    end

    task automatic tally_and_finish();
        $display("TB: %0d compares, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(inout int k);
        @(posedge clock);
        k++;
        if (k > 5000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : tick

    task automatic wait_ph(input dsa_phase_type p, output int k);
        k = 0;
        do tick(k); while (phase !== p);
    endtask : wait_ph

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do tick(k); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic conv(input logic pos, input int d,
                        input logic [19:0] ex, input logic ovr);
        int k;
        in_pos = pos;
        dlen = d;
        stb_t.delete();
        wait_ph(DSA_INTEG, k);
        chk("integ_sw", {s_in, s_z, s_rc, s_lp, busy}, 5'h11);
        if (t_int > 0)
            chk("frame", cyc - t_int, FRAME);
        t_int = cyc;
        wait_ph(DSA_DEINT, k);
        chk("integ_len", k, INT);
        chk("deint_sw", {s_rp, s_rn, s_lp, s_in}, {pos, !pos, 2'b10});
        wait_ph(DSA_IZERO, k);
        chk("deint_len", k, ovr ? DMAX + 1 : d + 1);
        t0 = cyc;
        chk("izero", {busy, polarity, overrange, s_lp, s_cl},
            {1'b0, pos, ovr, 2'b11});
        k = 0;
        do tick(k); while (phase === DSA_IZERO);
        chk("izero_len", k, ovr ? IZO : 200);
        chk("after_iz", phase, run_hold ? DSA_ZERO : DSA_HOLD);
        for (k = 0; stb_t.size() < 5; )
            tick(k);
        // Let the latch take the last digit before looking at it
        tick(k);
        chk("latched", word, ex);
        // Msd select trails the end of busy by one clock
        chk("first_stb", stb_t[0] - t0, 1 + 101);
        for (k = 1; k < 5; k++)
            chk("stb_gap", stb_t[k] - stb_t[k - 1], 200);
        if (ovr)
        begin
            repeat (20) @(posedge clock);
            chk("blank", {sel, bcd}, 9'h0);
        end
    endtask : conv

    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        chk("rst_out", {s_z, s_rc, s_lp, s_in, busy, strobe_n, sel},
            11'h730);
        apb(1'b0, 8'h04, 32'h0);
        chk("status", rd, 32'h10);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", {err, rd}, 33'h100000000);
        apb(1'b1, 8'h00, 32'h1);
        $display("test registers done");
        conv(1'b1, 7, 20'h00007, 1'b0);
        apb(1'b0, 8'h08, 32'h0);
        chk("result", rd, 32'h7);
        apb(1'b0, 8'h04, 32'h0);
        chk("status_ur", rd[3:0], 4'hA);
        conv(1'b0, 35, 20'h00035, 1'b0);
        conv(1'b1, 60, 20'h0, 1'b1);
        conv(1'b1, 12, 20'h00012, 1'b0);
        $display("test continuous done");
        run_hold <= 1'b0;
        t_int = 0;
        wait_ph(DSA_HOLD, n);
        // The cycle that ran on into hold still owes its strobes
        repeat (1000) @(posedge clock);
        stb_t.delete();
        for (n = 0; n < 2400; )
        begin
            tick(n);
            lsd_hi += (sel[0] === 1'b1);
        end
        chk("hold", {phase === DSA_HOLD, stb_t.size()}, 33'h100000000);
        chk("scan", lsd_hi >= 400, 1'b1);
        run_hold <= 1'b1;
        repeat (20) @(posedge clock);
        run_hold <= 1'b0;
        repeat (200) @(posedge clock);
        chk("short_pulse", phase === DSA_HOLD, 1'b1);
        run_hold <= 1'b1;
        wait_ph(DSA_ZERO, n);
        t_az = cyc;
        repeat (4) @(posedge clock);
        run_hold <= 1'b0;
        conv(1'b1, 9, 20'h00009, 1'b0);
        chk("az_len", t_int - t_az, AZ);
        wait_ph(DSA_HOLD, n);
        repeat (1500) @(posedge clock);
        chk("one_shot", {phase === DSA_HOLD, stb_t.size()}, 33'h100000005);
        $display("test hold done");
        tally_and_finish();
    end
endmodule : testbench
